/* rf_supply_alarm_supervisor.sv */
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "rf_alarm_params.svh"
module rf_supply_alarm_supervisor
    import rf_alarm_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic enable_in,
    input wire logic modulation_input,
    input wire logic mismatch_detect,
    input wire logic temp_valid,
    input wire logic [7:0] temp_value,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    output logic overtemp_flag_out,
    output logic mismatch_flag_out,
    output logic mod_limit_flag_out,
    output logic alarm_out,
    output logic ready_out,
    output logic rf_enable_out,
    output logic rf_limit_out
);
    logic rst_sync1_ff;
    logic rst_n;
    logic [31:0] tick_cnt_ff;
    logic tick_ff;
    logic enable_d_ff;
    sup_state_t state_ff;
    sup_state_t nxt_state;
    logic overtemp_ff;
    temp_deg_t temp_ff;
    logic mism_flag_ff;
    logic mism_latched_ff;
    ms_count_t persist_ff;
    logic mism_qual;
    logic [`EV_WIDTH-1:0] status_ff;
    logic [`EV_WIDTH-1:0] irq_en_ff;
    logic [`EV_WIDTH-1:0] events;
    logic [`EV_WIDTH-1:0] clr;
    logic mod_limit_d_ff;

    mod_monitor_if mif();

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync1_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync1_ff <= 1'b1;
            rst_n <= rst_sync1_ff;
        end
    end

    // ms prescaler
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (tick_cnt_ff == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    assign mif.tick = tick_ff;
    assign mif.modulation = modulation_input;

    mod_monitor u_mod_monitor (
        .clk(clk),
        .rst_n(rst_n),
        .mon(mif.monitor)
    );

    // temperature with hysteresis
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overtemp_ff <= 1'b0;
            temp_ff <= 8'h00;
        end else if (temp_valid) begin
            temp_ff <= temp_value;
            if (temp_value >= `OVERTEMP_ALARM_THRESHOLD) begin
                overtemp_ff <= 1'b1;
            end else if (temp_value <= `OVERTEMP_RELEASE_THRESHOLD) begin
                overtemp_ff <= 1'b0;
            end
        end
    end

    assign mism_qual = mismatch_detect && mif.detectable;

    // mismatch flag, persistence timer and shutdown latch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mism_flag_ff <= 1'b0;
            persist_ff <= 16'h0000;
            mism_latched_ff <= 1'b0;
        end else begin
            mism_flag_ff <= mism_qual;
            if (!mism_qual) begin
                persist_ff <= 16'h0000;
            end else if (tick_ff && persist_ff != 16'(`MISMATCH_PERSIST_TICKS)) begin
                persist_ff <= persist_ff + 16'h0001;
            end
            if (!enable_in) begin
                mism_latched_ff <= 1'b0;
            end else if (mism_qual && tick_ff && persist_ff == 16'(`MISMATCH_PERSIST_TICKS - 1)) begin
                mism_latched_ff <= 1'b1;
            end
        end
    end

    assign alarm_out = overtemp_ff || mism_latched_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_STANDBY: begin
                if (enable_in && !enable_d_ff && !alarm_out) begin
                    nxt_state = ST_READY;
                end
            end
            ST_READY: begin
                if (alarm_out) begin
                    nxt_state = ST_ALARM;
                end else if (!enable_in) begin
                    nxt_state = ST_STANDBY;
                end
            end
            ST_ALARM: begin
                if (!enable_in && !alarm_out) begin
                    nxt_state = ST_STANDBY;
                end
            end
            default: begin
                nxt_state = ST_STANDBY;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_STANDBY;
            enable_d_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            enable_d_ff <= enable_in;
        end
    end

    assign ready_out = (state_ff == ST_READY) && !alarm_out;
    assign overtemp_flag_out = overtemp_ff;
    assign mismatch_flag_out = mism_flag_ff;
    assign mod_limit_flag_out = mif.limit;
    assign rf_limit_out = mism_flag_ff;
    // RF follows modulation only when ready and inside limits
    assign rf_enable_out = ready_out && !mif.limit && modulation_input;

    // interrupt events
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mod_limit_d_ff <= 1'b0;
        end else begin
            mod_limit_d_ff <= mif.limit;
        end
    end

    always_comb begin
        events = '0;
        events[`EV_OVERTEMP] = temp_valid && !overtemp_ff && (temp_value >= `OVERTEMP_ALARM_THRESHOLD);
        events[`EV_MISMATCH] = mism_qual && !mism_flag_ff;
        events[`EV_SHUTDOWN] = mism_qual && tick_ff && (persist_ff == 16'(`MISMATCH_PERSIST_TICKS - 1)) && enable_in;
        events[`EV_MOD_LIMIT] = mif.limit && !mod_limit_d_ff;
        clr = (reg_wr && reg_addr == `REG_IRQ_CLEAR) ? reg_wdata[`EV_WIDTH-1:0] : '0;
    end

    // set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= '0;
        end else begin
            status_ff <= (status_ff & ~clr) | events;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_ff <= `IRQ_ENABLE_RESET;
        end else if (reg_wr && reg_addr == `REG_IRQ_ENABLE) begin
            irq_en_ff <= reg_wdata[`EV_WIDTH-1:0];
        end
    end

    assign irq = |(status_ff & irq_en_ff);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr == `REG_IRQ_STATUS) begin
                reg_rdata <= {28'h000_0000, status_ff};
            end else if (reg_addr == `REG_IRQ_ENABLE) begin
                reg_rdata <= {28'h000_0000, irq_en_ff};
            end else if (reg_addr == `REG_LIVE_STATE) begin
                reg_rdata <= {24'h00_0000, state_ff, ready_out, alarm_out, mif.limit, mism_flag_ff, overtemp_ff};
            end else if (reg_addr == `REG_TEMPERATURE) begin
                reg_rdata <= {24'h00_0000, temp_ff};
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    a_overtemp_set: assert property (@(posedge clk) disable iff (!rst_n)
        temp_valid && temp_value >= `OVERTEMP_ALARM_THRESHOLD |=> overtemp_flag_out && alarm_out)
        else $error("overtemp not flagged at alarm threshold");
    a_overtemp_hold: assert property (@(posedge clk) disable iff (!rst_n)
        overtemp_ff && !(temp_valid && temp_value <= `OVERTEMP_RELEASE_THRESHOLD) |=> overtemp_ff && !rf_enable_out)
        else $error("overtemp released above release threshold");
    a_flag_follows: assert property (@(posedge clk) disable iff (!rst_n)
        mism_qual |=> mismatch_flag_out)
        else $error("mismatch flag did not follow condition");
    a_flag_drops: assert property (@(posedge clk) disable iff (!rst_n)
        !mism_qual |=> !mismatch_flag_out)
        else $error("mismatch flag stayed with condition gone");
    a_mismatch_limit: assert property (@(posedge clk) disable iff (!rst_n)
        mismatch_flag_out && !mism_latched_ff |-> rf_limit_out && !alarm_out || overtemp_ff)
        else $error("mismatch did not limit power");
    a_shutdown_latch: assert property (@(posedge clk) disable iff (!rst_n)
        enable_in && mism_qual && tick_ff && persist_ff == 16'(`MISMATCH_PERSIST_TICKS - 1) |=> alarm_out ##1 !rf_enable_out)
        else $error("mismatch persistence did not shut down");
    a_enable_clears: assert property (@(posedge clk) disable iff (!rst_n)
        !enable_in |=> !mism_latched_ff)
        else $error("enable low did not clear mismatch latch");
    a_no_mod_alarm: assert property (@(posedge clk) disable iff (!rst_n)
        mod_limit_flag_out && !overtemp_ff && !mism_latched_ff |-> !alarm_out && !rf_enable_out)
        else $error("modulation limit drove alarm or left rf on");
    a_ready_drop: assert property (@(posedge clk) disable iff (!rst_n)
        alarm_out |-> !ready_out ##1 (state_ff != ST_READY))
        else $error("ready stayed with alarm");
    a_timer_restart: assert property (@(posedge clk) disable iff (!rst_n)
        !mism_qual |=> persist_ff == 16'h0000)
        else $error("persistence timer not restarted");
    a_timer_counts: assert property (@(posedge clk) disable iff (!rst_n)
        mism_qual && tick_ff && persist_ff != 16'(`MISMATCH_PERSIST_TICKS) |=> persist_ff == $past(persist_ff) + 16'h0001)
        else $error("persistence timer missed a tick");
    a_overtemp_clear: assert property (@(posedge clk) disable iff (!rst_n)
        temp_valid && temp_value <= `OVERTEMP_RELEASE_THRESHOLD |=> !overtemp_flag_out)
        else $error("overtemp not released at release threshold");
    a_overtemp_alarm: assert property (@(posedge clk) disable iff (!rst_n)
        overtemp_flag_out |-> alarm_out)
        else $error("overtemp without common alarm");
    a_alarm_blocks_rf: assert property (@(posedge clk) disable iff (!rst_n)
        alarm_out |-> !rf_enable_out && !ready_out)
        else $error("rf or ready left on during alarm");
    a_limit_cuts_rf: assert property (@(posedge clk) disable iff (!rst_n)
        mod_limit_flag_out |-> !rf_enable_out)
        else $error("rf left on during modulation limit");
    a_rf_follows_mod: assert property (@(posedge clk) disable iff (!rst_n)
        ready_out && !mod_limit_flag_out |-> rf_enable_out == modulation_input)
        else $error("rf does not follow modulation");
    a_limit_keeps_ready: assert property (@(posedge clk) disable iff (!rst_n)
        mod_limit_flag_out && state_ff == ST_READY && enable_in && !alarm_out |=> state_ff == ST_READY)
        else $error("modulation limit left ready state");
    a_latch_holds: assert property (@(posedge clk) disable iff (!rst_n)
        mism_latched_ff && enable_in |=> mism_latched_ff)
        else $error("mismatch latch released with enable high");
    a_mismatch_qualified: assert property (@(posedge clk) disable iff (!rst_n)
        mismatch_flag_out |-> $past(mif.detectable))
        else $error("mismatch flagged without usable modulation");
    c_ready: cover property (@(posedge clk) disable iff (!rst_n) $rose(ready_out));
    c_shutdown: cover property (@(posedge clk) disable iff (!rst_n) $rose(mism_latched_ff));
    c_overtemp_release: cover property (@(posedge clk) disable iff (!rst_n) $fell(overtemp_ff));
    c_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
endmodule

/* rf_alarm_params.svh */
`ifndef RF_ALARM_PARAMS_SVH
`define RF_ALARM_PARAMS_SVH

`define CLK_PERIOD_NS 20
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES ((`TICK_PERIOD_NS) / (`CLK_PERIOD_NS))
`define MISMATCH_PERSIST_S 5
`define MISMATCH_PERSIST_TICKS (`MISMATCH_PERSIST_S * 1000)

`define OVERTEMP_ALARM_THRESHOLD 8'h41
`define OVERTEMP_RELEASE_THRESHOLD 8'h2d

`define DETECT_PULSE_MS 200
`define DETECT_DUTY_PCT 15
`define MOD_MAX_PULSE_MS 1000
`define MOD_MAX_DUTY_PCT 50
`define DUTY_WINDOW_MS 1000
`define DETECT_DUTY_TICKS (`DETECT_DUTY_PCT * `DUTY_WINDOW_MS / 100)
`define MOD_MAX_DUTY_TICKS (`MOD_MAX_DUTY_PCT * `DUTY_WINDOW_MS / 100)

`define REG_IRQ_STATUS 8'h00
`define REG_IRQ_CLEAR 8'h04
`define REG_IRQ_ENABLE 8'h08
`define REG_LIVE_STATE 8'h0c
`define REG_TEMPERATURE 8'h10

`define EV_OVERTEMP 0
`define EV_MISMATCH 1
`define EV_SHUTDOWN 2
`define EV_MOD_LIMIT 3
`define EV_WIDTH 4

`define IRQ_ENABLE_RESET 4'h0

`endif

/* rf_alarm_pkg.sv */
package rf_alarm_pkg;
    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_READY   = 3'b010,
        ST_ALARM   = 3'b100
    } sup_state_t;
    typedef logic [15:0] ms_count_t;
    typedef logic [7:0] temp_deg_t;
endpackage

/* mod_monitor_if.sv */
`timescale 1ns/100ps
interface mod_monitor_if;
    logic tick;
    logic modulation;
    logic limit;
    logic detectable;
    modport monitor(input tick, input modulation, output limit, output detectable);
    modport supervisor(output tick, output modulation, input limit, input detectable);
endinterface

/* mod_monitor.sv */
`timescale 1ns/100ps
`include "rf_alarm_params.svh"
module mod_monitor
    import rf_alarm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    mod_monitor_if.monitor mon
);
    ms_count_t run_ff;
    ms_count_t win_ff;
    ms_count_t high_ff;
    ms_count_t last_high_ff;
    logic limit_ff;
    logic detect_ff;
    logic nxt_limit;
    logic nxt_detect;

    // length of the current pulse in ms, saturating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_ff <= 16'h0000;
        end else if (!mon.modulation) begin
            run_ff <= 16'h0000;
        end else if (mon.tick && run_ff != 16'hffff) begin
            run_ff <= run_ff + 16'h0001;
        end
    end

    // high time over a fixed window gives the duty cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_ff <= 16'h0000;
            high_ff <= 16'h0000;
            last_high_ff <= 16'h0000;
        end else if (mon.tick) begin
            if (win_ff == 16'(`DUTY_WINDOW_MS - 1)) begin
                win_ff <= 16'h0000;
                high_ff <= 16'h0000;
                last_high_ff <= high_ff + {15'h0000, mon.modulation};
            end else begin
                win_ff <= win_ff + 16'h0001;
                high_ff <= high_ff + {15'h0000, mon.modulation};
            end
        end
    end

    always_comb begin
        nxt_limit = (run_ff > 16'(`MOD_MAX_PULSE_MS)) || (last_high_ff > 16'(`MOD_MAX_DUTY_TICKS));
        nxt_detect = (run_ff > 16'(`DETECT_PULSE_MS)) || (last_high_ff > 16'(`DETECT_DUTY_TICKS));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            limit_ff <= 1'b0;
            detect_ff <= 1'b0;
        end else begin
            limit_ff <= nxt_limit;
            detect_ff <= nxt_detect;
        end
    end

    assign mon.limit = limit_ff;
    assign mon.detectable = detect_ff;

    a_long_pulse_limit: assert property (@(posedge clk) disable iff (!rst_n)
        run_ff > 16'(`MOD_MAX_PULSE_MS) |=> limit_ff)
        else $error("long pulse did not raise modulation limit");
    a_limit_release: assert property (@(posedge clk) disable iff (!rst_n)
        (run_ff <= 16'(`MOD_MAX_PULSE_MS)) && (last_high_ff <= 16'(`MOD_MAX_DUTY_TICKS)) |=> !limit_ff)
        else $error("modulation limit held with parameters in range");
    a_detect_window: assert property (@(posedge clk) disable iff (!rst_n)
        detect_ff |-> $past(run_ff) > 16'(`DETECT_PULSE_MS) || $past(last_high_ff) > 16'(`DETECT_DUTY_TICKS))
        else $error("mismatch detection enabled for short sparse modulation");
    c_limit_seen: cover property (@(posedge clk) disable iff (!rst_n) $rose(limit_ff));
endmodule

/* controller_model.sv */
`timescale 1ns/100ps
// machine controller on the far side: enable and modulation lines
module controller_model #(
    parameter int MS = 5
)
(
    input wire logic clk,
    output logic enable_in,
    output logic modulation_input
);
    localparam int PWM_HI = 150 * MS;
    localparam int PWM_PER = 500 * MS;
    logic en_req = 1'b0;
    logic mod_level = 1'b0;
    logic pwm_on = 1'b0;
    int low_cnt = 0;
    int ph = 0;
    always @(posedge clk) begin
        enable_in <= en_req;
        low_cnt <= en_req ? 0 : low_cnt + 1;
        ph <= (pwm_on && ph < PWM_PER - 1) ? ph + 1 : 0;
        modulation_input <= pwm_on ? (ph < PWM_HI) : mod_level;
    end
    task drop_enable;
        en_req <= 1'b0;
    endtask
    // enable goes high again only after a full second low
    task raise_enable;
        int k;
        for (k = 0; k < 2000 * MS && low_cnt < 1000 * MS; k++) begin
            @(posedge clk);
        end
        en_req <= 1'b1;
    endtask
endmodule

/* rf_supply_alarm_supervisor_test.sv */
`timescale 1ns/100ps
`include "rf_alarm_params.svh"
module rf_supply_alarm_supervisor_test;
    import rf_alarm_pkg::*;
    localparam int MS = 5;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic enable_in;
    logic modulation_input;
    logic mismatch_detect = 1'b0;
    logic temp_valid = 1'b0;
    logic [7:0] temp_value = 8'h00;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] rd_word;
    logic irq, overtemp_flag_out, mismatch_flag_out, mod_limit_flag_out;
    logic alarm_out, ready_out, rf_enable_out, rf_limit_out;
    int n_mismatch = 0;
    int compares = 0;
    int n;
    initial begin
        forever #10 clk = ~clk;
    end
    controller_model #(.MS(MS)) ctl (.clk(clk), .enable_in(enable_in), .modulation_input(modulation_input));
    rf_supply_alarm_supervisor #(.TICK_CYCLES(MS)) uut (.clk(clk), .rstn(rstn), .enable_in(enable_in),
        .modulation_input(modulation_input), .mismatch_detect(mismatch_detect), .temp_valid(temp_valid),
        .temp_value(temp_value), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .overtemp_flag_out(overtemp_flag_out),
        .mismatch_flag_out(mismatch_flag_out), .mod_limit_flag_out(mod_limit_flag_out),
        .alarm_out(alarm_out), .ready_out(ready_out), .rf_enable_out(rf_enable_out),
        .rf_limit_out(rf_limit_out));
    function automatic logic pick(input int k);
        case (k)
            0: return overtemp_flag_out;
            1: return mismatch_flag_out;
            2: return mod_limit_flag_out;
            3: return alarm_out;
            default: return ready_out;
        endcase
    endfunction
    task give_verdict;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task check_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: %s got %b", $time, what, got);
        end
    endtask
    task check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: %s got %h", $time, what, got);
        end
    endtask
    task wait_for(input int k, input logic v, input int lim, output int cnt);
        cnt = 0;
        while (pick(k) !== v) begin
            if (cnt >= lim) begin
                n_mismatch++;
                $display("ERROR at %0t: wait on output %0d timed out", $time, k);
                give_verdict();
            end
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask
    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task temp_sample(input logic [7:0] v);
        @(posedge clk);
        temp_valid <= 1'b1;
        temp_value <= v;
        @(posedge clk);
        temp_valid <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task t_reset;
        repeat (10) @(posedge clk);
        #1;
        check_bit(alarm_out | overtemp_flag_out, 1'b0, "alarm in reset");
        check_bit(ready_out | rf_enable_out | irq, 1'b0, "outputs in reset");
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        reg_read(`REG_IRQ_ENABLE, rd_word);
        check_word(rd_word, 32'h0, "irq enable reset");
        reg_read(8'h20, rd_word);
        check_word(rd_word, 32'h0, "unmapped read");
        reg_read(`REG_LIVE_STATE, rd_word);
        check_word(rd_word, 32'h20, "standby state");
    endtask
    task t_ready;
        ctl.raise_enable();
        wait_for(4, 1'b1, 4, n);
        ctl.mod_level <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check_bit(rf_enable_out, 1'b1, "rf follows modulation");
    endtask
    task t_overtemp;
        temp_sample(8'h40);
        check_bit(overtemp_flag_out, 1'b0, "flag at 64");
        temp_sample(8'h41);
        check_bit(overtemp_flag_out, 1'b1, "flag at 65");
        check_bit(alarm_out, 1'b1, "alarm at 65");
        check_bit(ready_out, 1'b0, "ready in alarm");
        check_bit(mismatch_flag_out | mod_limit_flag_out, 1'b0, "other flags");
        check_bit(irq, 1'b0, "masked irq");
        reg_read(`REG_LIVE_STATE, rd_word);
        check_word(rd_word, 32'h89, "live in alarm");
        reg_read(`REG_IRQ_STATUS, rd_word);
        check_word(rd_word, 32'h1, "status overtemp");
        reg_write(`REG_IRQ_ENABLE, 32'h1);
        @(posedge clk);
        #1;
        check_bit(irq, 1'b1, "irq enabled");
        reg_write(`REG_IRQ_CLEAR, 32'h1);
        @(posedge clk);
        #1;
        check_bit(irq, 1'b0, "irq cleared");
        temp_sample(8'h2e);
        check_bit(overtemp_flag_out & alarm_out, 1'b1, "held at 46");
        check_bit(rf_enable_out, 1'b0, "rf off at 46");
        temp_sample(8'h2d);
        check_bit(overtemp_flag_out | alarm_out, 1'b0, "release at 45");
        ctl.mod_level <= 1'b0;
        ctl.drop_enable();
        ctl.raise_enable();
        wait_for(4, 1'b1, 4, n);
    endtask
    task t_modlimit;
        ctl.mod_level <= 1'b1;
        wait_for(2, 1'b1, 1100 * MS, n);
        check_bit(rf_enable_out, 1'b0, "rf off on limit");
        check_bit(alarm_out, 1'b0, "no alarm on limit");
        check_bit(ready_out, 1'b1, "ready on limit");
        ctl.mod_level <= 1'b0;
        wait_for(2, 1'b0, 1100 * MS, n);
        ctl.mod_level <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check_bit(rf_enable_out, 1'b1, "rf back after limit");
        ctl.mod_level <= 1'b0;
    endtask
    task t_mismatch;
        repeat (1100 * MS) @(posedge clk);
        mismatch_detect <= 1'b1;
        repeat (100 * MS) @(posedge clk);
        #1;
        check_bit(mismatch_flag_out, 1'b0, "unqualified mismatch");
        ctl.pwm_on <= 1'b1;
        wait_for(1, 1'b1, 2100 * MS, n);
        check_bit(rf_limit_out, 1'b1, "power limited");
        check_bit(alarm_out, 1'b0, "no early cut");
        wait_for(3, 1'b1, 5100 * MS, n);
        check_bit(n >= (`MISMATCH_PERSIST_TICKS - 1) * MS - 1, 1'b1, "shutdown too early");
        check_bit(rf_enable_out | ready_out, 1'b0, "rf cut and not ready");
        @(posedge clk);
        mismatch_detect <= 1'b0;
        ctl.pwm_on <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        check_bit(alarm_out, 1'b1, "alarm latched");
        check_bit(mismatch_flag_out | rf_limit_out, 1'b0, "mismatch flag off when gone");
        ctl.drop_enable();
        repeat (4) @(posedge clk);
        #1;
        check_bit(alarm_out, 1'b0, "alarm cleared by enable low");
        ctl.raise_enable();
        wait_for(4, 1'b1, 4, n);
        reg_read(`REG_IRQ_STATUS, rd_word);
        check_word(rd_word, 32'he, "status events");
        reg_read(`REG_TEMPERATURE, rd_word);
        check_word(rd_word, 32'h2d, "last sample");
        reg_read(`REG_IRQ_CLEAR, rd_word);
        check_word(rd_word, 32'h0, "clear reads zero");
        check_bit(irq, 1'b0, "masked events");
    endtask
    initial begin
        t_reset();
        t_ready();
        t_overtemp();
        t_modlimit();
        t_mismatch();
        give_verdict();
    end
endmodule
